// [verilog/alm_monitor.sv]
// Alarm, upset and link enable monitor of the serial transmit section
//
// How it works
// - Each alarm source sets one status bit; clock upset and power-down exit share one
// - Status bits stay set until written one
// - Unmasked alarms drive the summary alarm
// - Status pin shows alarm when selected
// - Any NCO accumulator mismatch sets sticky flag
// - NCO compare valid only after NCO sync
// - Channel B NCO select independent of A
// - Half-rate clock mismatch sets sticky flag
// - Power-down exit may set clock flag
// - Link disabled: reset, power down, gate clocks
// - SYSREF resets local multiframe clock counter
// - Subclass 0 self-runs clock, honours SYNC in 8B/10B
// - FIFO errors set alarm and lane flag
// - Optional reinit on FIFO alarm
`default_nettype none
module alm_monitor
    import alm_pkg::*;
#(
    parameter int LANES = 16,
    parameter int NCO_W = 32,
    parameter int CLK_W = 4
) (
    // Clock and reset
    input wire logic                mclk,
    input wire logic                resetn,
    // Register port
    input wire logic [ADDR_W-1:0]   addr,
    input wire logic [DATA_W-1:0]   wdata,
    input wire logic                wr,
    input wire logic                rd,
    output logic [DATA_W-1:0]       rdata_q,
    // Asynchronous pins
    input wire logic                sysref,
    input wire logic                sync_n,
    input wire logic                power_down_pin,
    input wire logic                pll_locked,
    input wire logic [1:0]          channel_a_nco_select_pins,
    input wire logic [1:0]          channel_b_nco_select_pins,
    // Link layer status
    input wire logic [LANES-1:0]    lane_fifo_error,
    input wire logic                link_in_data_state,
    input wire logic                ilas_start,
    // Channel comparison taps
    input wire logic [NCO_W-1:0]    nco_acc_a,
    input wire logic [NCO_W-1:0]    nco_acc_b,
    input wire logic [CLK_W-1:0]    clk_phase_a,
    input wire logic [CLK_W-1:0]    clk_phase_b,
    // Link control
    output logic                    link_reset_n_q,
    output logic                    serializer_power_down_q,
    output logic                    link_clock_enable_q,
    output logic                    fifo_reinit_q,
    output logic                    link_sync_request_q,
    output logic                    lmfc_edge_q,
    output logic                    nco_sync_pulse_q,
    output logic [1:0]              nco_select_a_q,
    output logic [1:0]              nco_select_b_q,
    // Alarm outputs
    output logic                    summary_alarm_q,
    output logic                    calibration_status_pin_q
);
    localparam int PIN_W = 8;

    // Registers
    logic [CTL_W-1:0]   ctrl_q;
    logic [N_ALARM-1:0] mask_q;
    logic [15:0]        mf_period_q;
    logic [1:0]         power_q;
    logic [4:0]         nco_sel_q;

    // Pin synchroniser
    logic [PIN_W-1:0]   pin_meta_q;
    logic [PIN_W-1:0]   pin_sync_q;
    logic [PIN_W-1:0]   pin_prev_q;
    logic [PIN_W-1:0]   pin_raw;

    // Internal state
    logic [15:0]        mf_cnt_q;
    logic [15:0]        mf_cnt_d;
    logic               nco_synced_q;
    logic               half_en_q;
    logic               pd_exit_q;

    alm_flag_if #(.W(N_ALARM)) alm ();
    alm_flag_if #(.W(LANES)) lane ();

    alm_sticky #(.W(N_ALARM)) u_alarm (
        .mclk   (mclk),
        .resetn (resetn),
        .flags  (alm)
    );

    alm_sticky #(.W(LANES)) u_lane (
        .mclk   (mclk),
        .resetn (resetn),
        .flags  (lane)
    );

    // Pins pass two flip-flops before any logic reads them
    assign pin_raw = {channel_b_nco_select_pins, channel_a_nco_select_pins,
                      pll_locked, power_down_pin, sync_n, sysref};

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_q <= 8'h06;
            pin_sync_q <= 8'h06;
            pin_prev_q <= 8'h06;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Synchronised pin views
    wire       sysref_s   = pin_sync_q[0];
    wire       sync_n_s   = pin_sync_q[1];
    wire       pd_s       = pin_sync_q[2];
    wire       pll_s      = pin_sync_q[3];
    wire [1:0] sel_a_pin  = pin_sync_q[5:4];
    wire [1:0] sel_b_pin  = pin_sync_q[7:6];
    wire       sysref_cap = sysref_s & ~pin_prev_q[0];
    wire       pd_release = ~pd_s & pin_prev_q[2];

    // Control decode
    wire link_en     = ctrl_q[CTL_LINK_EN];
    wire reinit_en   = ctrl_q[CTL_REINIT];
    wire enc_64b     = ctrl_q[CTL_ENC_64B];
    wire subclass0   = ctrl_q[CTL_SUBCLASS0];
    wire nco_by_ilas = ctrl_q[CTL_NCO_BY_ILAS];
    wire pin_alarm   = ctrl_q[CTL_PIN_ALARM];
    wire both_on     = ~power_q[PWR_CH_A] & ~power_q[PWR_CH_B] & ~pd_s;

    // Register decode
    wire wr_ctrl   = wr && (addr == OFS_LINK_CTRL);
    wire wr_status = wr && (addr == OFS_ALARM_STATUS_BITS);
    wire wr_mask   = wr && (addr == OFS_ALM_MASK);
    wire wr_lane   = wr && (addr == OFS_LANE_ALM);
    wire wr_period = wr && (addr == OFS_MF_PERIOD);
    wire wr_power  = wr && (addr == OFS_POWER);
    wire wr_nsel   = wr && (addr == OFS_NCO_SEL);

    // Half-rate enable for the clock comparator
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            half_en_q <= 1'b0;
        end else begin
            half_en_q <= ~half_en_q;
        end
    end

    // Local multiframe or extended multiblock counter; SYSREF realigns
    // it unless subclass 0, where it free-runs with arbitrary phase
    wire mf_wrap = (mf_cnt_q >= mf_period_q - 16'h0001);
    wire sysref_use = sysref_cap & ~subclass0 & link_en;
    wire sysref_realign = sysref_use & (mf_cnt_q != 16'h0000);

    always_comb begin
        mf_cnt_d = mf_cnt_q + 16'h0001;
        if (!link_en) begin
            mf_cnt_d = 16'h0000;
        end else if (sysref_use) begin
            mf_cnt_d = 16'h0000;
        end else if (mf_wrap) begin
            mf_cnt_d = 16'h0000;
        end
    end

    // Period register picks frames per multiframe in 8B/10B mode or
    // blocks per extended multiblock in 64B/66B mode; both share it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mf_cnt_q    <= 16'h0000;
            lmfc_edge_q <= 1'b0;
        end else begin
            mf_cnt_q    <= mf_cnt_d;
            lmfc_edge_q <= link_en & (mf_cnt_d == 16'h0000);
        end
    end

    // NCO synchronisation by SYSREF or by start of lane alignment
    wire nco_sync_evt = link_en & (nco_by_ilas ? ilas_start : sysref_cap);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            nco_synced_q     <= 1'b0;
            nco_sync_pulse_q <= 1'b0;
        end else begin
            nco_sync_pulse_q <= nco_sync_evt;
            if (!link_en || !both_on) begin
                nco_synced_q <= 1'b0;
            end else if (nco_sync_evt) begin
                nco_synced_q <= 1'b1;
            end
        end
    end

    // Power-down exit is registered as a one-cycle event
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pd_exit_q <= 1'b0;
        end else begin
            pd_exit_q <= pd_release;
        end
    end

    // Alarm events
    wire fifo_evt = |lane_fifo_error;
    wire nco_mis  = nco_synced_q & (nco_acc_a != nco_acc_b);
    wire clk_mis  = half_en_q & both_on & (clk_phase_a != clk_phase_b);

    assign alm.set[ALM_FIFO]     = fifo_evt;
    assign alm.set[ALM_PLL]      = link_en & ~pll_s;
    assign alm.set[ALM_NOT_DATA] = link_en & ~link_in_data_state;
    assign alm.set[ALM_SYSREF]   = sysref_realign;
    assign alm.set[ALM_NCO]      = nco_mis;
    assign alm.set[ALM_CLK]      = clk_mis | pd_exit_q;
    assign alm.clr = wr_status ? wdata[N_ALARM-1:0] : '0;

    assign lane.set = lane_fifo_error;
    assign lane.clr = wr_lane ? wdata[LANES-1:0] : '0;

    wire summary = |(alm.q & ~mask_q);

    // Register writes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q      <= RST_LINK_CTRL;
            mask_q      <= RST_ALM_MASK;
            mf_period_q <= RST_MF_PERIOD;
            power_q     <= RST_POWER;
            nco_sel_q   <= RST_NCO_SEL;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wdata[CTL_W-1:0];
            end
            if (wr_mask) begin
                mask_q <= wdata[N_ALARM-1:0];
            end
            if (wr_period && wdata[15:0] != 16'h0000) begin
                mf_period_q <= wdata[15:0];
            end
            if (wr_power) begin
                power_q <= wdata[1:0];
            end
            if (wr_nsel) begin
                nco_sel_q <= wdata[4:0];
            end
        end
    end

    // Read mux; unmapped addresses read zero
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        unique case (addr)
            OFS_LINK_CTRL:  rd_mux[CTL_W-1:0]   = ctrl_q;
            OFS_ALARM_STATUS_BITS: rd_mux[N_ALARM-1:0] = alm.q;
            OFS_ALM_MASK:   rd_mux[N_ALARM-1:0] = mask_q;
            OFS_SUMMARY:    rd_mux[1:0] = {nco_synced_q, summary};
            OFS_LANE_ALM:   rd_mux[LANES-1:0]   = lane.q;
            OFS_MF_PERIOD:  rd_mux[15:0]        = mf_period_q;
            OFS_POWER:      rd_mux[1:0]         = power_q;
            OFS_NCO_SEL:    rd_mux[4:0]         = nco_sel_q;
            default:        rd_mux = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd ? rd_mux : '0;
        end
    end

    // FIFO error restarts serializers, FIFO and link for as long as it lasts
    wire reinit = reinit_en & fifo_evt & link_en;

    // Channel B select follows its own pins or register field,
    // never channel A, so the two may run different frequencies
    wire [1:0] sel_a = nco_sel_q[NSEL_SRC] ?
                       nco_sel_q[NSEL_A_LSB +: 2] : sel_a_pin;
    wire [1:0] sel_b = nco_sel_q[NSEL_SRC] ?
                       nco_sel_q[NSEL_B_LSB +: 2] : sel_b_pin;

    // Outputs; link section held idle while disabled
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            link_reset_n_q           <= 1'b0;
            serializer_power_down_q  <= 1'b1;
            link_clock_enable_q      <= 1'b0;
            fifo_reinit_q            <= 1'b0;
            link_sync_request_q      <= 1'b0;
            nco_select_a_q           <= 2'h0;
            nco_select_b_q           <= 2'h0;
            summary_alarm_q          <= 1'b0;
            calibration_status_pin_q <= 1'b0;
        end else begin
            link_reset_n_q           <= link_en & ~reinit;
            serializer_power_down_q  <= ~link_en | reinit;
            link_clock_enable_q      <= link_en;
            fifo_reinit_q            <= reinit;
            link_sync_request_q      <= link_en & ~enc_64b & ~sync_n_s;
            nco_select_a_q           <= sel_a;
            nco_select_b_q           <= sel_b;
            summary_alarm_q          <= summary;
            calibration_status_pin_q <= pin_alarm & summary;
        end
    end
endmodule
`default_nettype wire

// [common/alm_pkg.sv]
// Shared constants for the alarm and link monitor
`default_nettype none
package alm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int N_ALARM = 6;

    // Register offsets
    localparam logic [7:0] OFS_LINK_CTRL = 8'h00;
    localparam logic [7:0] OFS_ALARM_STATUS_BITS = 8'h04;
    localparam logic [7:0] OFS_ALM_MASK = 8'h08;
    localparam logic [7:0] OFS_SUMMARY = 8'h0C;
    localparam logic [7:0] OFS_LANE_ALM = 8'h10;
    localparam logic [7:0] OFS_MF_PERIOD = 8'h14;
    localparam logic [7:0] OFS_POWER = 8'h18;
    localparam logic [7:0] OFS_NCO_SEL = 8'h1C;

    // Control register fields
    localparam int CTL_LINK_EN = 0;
    localparam int CTL_REINIT = 1;
    localparam int CTL_ENC_64B = 2;
    localparam int CTL_SUBCLASS0 = 3;
    localparam int CTL_NCO_BY_ILAS = 4;
    localparam int CTL_PIN_ALARM = 5;
    localparam int CTL_W = 6;

    // Alarm status bit positions
    localparam int ALM_FIFO = 0;
    localparam int ALM_PLL = 1;
    localparam int ALM_NOT_DATA = 2;
    localparam int ALM_SYSREF = 3;
    localparam int ALM_NCO = 4;
    localparam int ALM_CLK = 5;

    // Summary fields
    localparam int SUM_ALARM = 0;
    localparam int SUM_NCO_SYNCED = 1;

    // Power register fields
    localparam int PWR_CH_A = 0;
    localparam int PWR_CH_B = 1;

    // NCO select register: bit 0 source, bits 2:1 chan A, bits 4:3 chan B
    localparam int NSEL_SRC = 0;
    localparam int NSEL_A_LSB = 1;
    localparam int NSEL_B_LSB = 3;

    // Reset values
    localparam logic [CTL_W-1:0] RST_LINK_CTRL = 6'h00;
    localparam logic [N_ALARM-1:0] RST_ALM_MASK = 6'h00;
    localparam logic [15:0] RST_MF_PERIOD = 16'h0020;
    localparam logic [1:0] RST_POWER = 2'h0;
    localparam logic [4:0] RST_NCO_SEL = 5'h00;

    // Clock and comparator timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_CMP_DIV = 2;
endpackage
`default_nettype wire

// [common/alm_flag_if.sv]
// Set, clear and state of a bank of sticky flags
`default_nettype none
interface alm_flag_if #(parameter int W = 1);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] q;
    modport owner (input set, input clr, output q);
    modport user (output set, output clr, input q);
endinterface
`default_nettype wire

// [verilog/alm_sticky.sv]
// Bank of sticky flags, set by events and cleared by writing ones
`default_nettype none
module alm_sticky #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic    mclk,
    input wire logic    resetn,
    // Flag bank
    alm_flag_if.owner   flags
);
    logic [W-1:0] q_q;
    logic [W-1:0] q_d;

    // An event in the clearing cycle keeps its bit set
    assign q_d = (q_q & ~flags.clr) | flags.set;
    assign flags.q = q_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end
endmodule
`default_nettype wire

// [tb/alm_monitor_chk.sv]
// Port-level checks of the alarm monitor
`default_nettype none
module alm_monitor_chk
    import alm_pkg::*;
#(
    parameter int LANES = 16
) (
    // Clock and reset
    input wire logic             mclk,
    input wire logic             resetn,
    // Register port
    input wire logic             wr,
    input wire logic             rd,
    input wire logic [DATA_W-1:0] rdata_q,
    // Link side
    input wire logic [LANES-1:0] lane_fifo_error,
    input wire logic             link_reset_n_q,
    input wire logic             serializer_power_down_q,
    input wire logic             link_clock_enable_q,
    input wire logic             fifo_reinit_q,
    input wire logic             lmfc_edge_q,
    // Alarm outputs
    input wire logic             summary_alarm_q,
    input wire logic             calibration_status_pin_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_rd_idle;
        !$past(rd) |-> rdata_q == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_pin_cause;
        calibration_status_pin_q |-> summary_alarm_q || $past(summary_alarm_q);
    endproperty
    a_pin_cause: assert property (p_pin_cause)
        else $error("status pin high without alarm");
    property p_gate_reset;
        !link_clock_enable_q |-> !link_reset_n_q;
    endproperty
    a_gate_reset: assert property (p_gate_reset)
        else $error("link clocks gated but block out of reset");
    property p_reset_pd;
        !link_reset_n_q |-> serializer_power_down_q;
    endproperty
    a_reset_pd: assert property (p_reset_pd)
        else $error("serializers powered while link in reset");
    property p_reinit_pd;
        fifo_reinit_q |-> !link_reset_n_q && serializer_power_down_q;
    endproperty
    a_reinit_pd: assert property (p_reinit_pd)
        else $error("reinit without link reset");
    property p_reinit_cause;
        fifo_reinit_q |-> $past(|lane_fifo_error);
    endproperty
    a_reinit_cause: assert property (p_reinit_cause)
        else $error("reinit without lane error");
    property p_sum_hold;
        summary_alarm_q && !wr && !$past(wr) |=> summary_alarm_q;
    endproperty
    a_sum_hold: assert property (p_sum_hold)
        else $error("alarm dropped without a write");
    property p_sum_clear;
        $fell(summary_alarm_q) |-> $past(wr) || $past(wr, 2);
    endproperty
    a_sum_clear: assert property (p_sum_clear)
        else $error("alarm fell with no write");
    c_reinit: cover property (fifo_reinit_q);
    c_pin: cover property ($rose(calibration_status_pin_q));
    c_sum: cover property ($rose(summary_alarm_q));
    c_edge: cover property (lmfc_edge_q);
endmodule
bind alm_monitor alm_monitor_chk #(.LANES(LANES)) alm_monitor_chk_inst (
    .mclk(mclk), .resetn(resetn), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .lane_fifo_error(lane_fifo_error), .link_reset_n_q(link_reset_n_q),
    .serializer_power_down_q(serializer_power_down_q),
    .link_clock_enable_q(link_clock_enable_q),
    .fifo_reinit_q(fifo_reinit_q), .lmfc_edge_q(lmfc_edge_q),
    .summary_alarm_q(summary_alarm_q),
    .calibration_status_pin_q(calibration_status_pin_q));
`default_nettype wire

// [tb/alm_rx_model.sv]
// Receiver model: requests sync, starts alignment, then carries data
`default_nettype none
module alm_rx_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Link side
    input wire logic link_reset_n_q,
    output logic     sync_n,
    output logic     ilas_start,
    output logic     link_in_data_state
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] step_q;
    // Restarts whenever the link block is put back in reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) step_q <= 4'h0;
        else if (!link_reset_n_q) step_q <= 4'h0;
        else if (step_q != 4'hF) step_q <= step_q + 4'h1;
    end
    assign sync_n = step_q >= 4'h6;
    assign ilas_start = step_q == 4'h8;
    assign link_in_data_state = step_q >= 4'hA;
endmodule
`default_nettype wire

// [tb/alm_monitor_tb.sv]
// Register-level tests of the alarm monitor
`default_nettype none
module alm_monitor_tb;
    import alm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, resetn, wr, rd, sysref, sync_n, pd_pin, pll_locked;
    logic ilas_start, in_data, nco_bump, clk_bump;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata_q, d, nco_acc_a, nco_acc_b;
    logic [1:0]  sel_a, sel_b, nsel_a_q, nsel_b_q;
    logic [15:0] lane_err;
    logic [3:0]  clk_a, clk_b;
    logic        lrst_n, ser_pd, lclk_en, reinit, sreq, edge_q, nsync;
    logic        sum_q, pin_q;
    int          n_errors, samples_checked, k;
    logic [7:0]  ofs[6] = '{8'h00, 8'h08, 8'h14, 8'h18, 8'h1C, 8'h40};
    logic [31:0] rstv[6] = '{32'h0, 32'h0, 32'h20, 32'h0, 32'h0, 32'h0};
    alm_monitor alm_monitor_inst (.mclk(mclk), .resetn(resetn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
        .sysref(sysref), .sync_n(sync_n), .power_down_pin(pd_pin),
        .pll_locked(pll_locked), .channel_a_nco_select_pins(sel_a),
        .channel_b_nco_select_pins(sel_b), .lane_fifo_error(lane_err),
        .link_in_data_state(in_data), .ilas_start(ilas_start),
        .nco_acc_a(nco_acc_a), .nco_acc_b(nco_acc_b), .clk_phase_a(clk_a),
        .clk_phase_b(clk_b), .link_reset_n_q(lrst_n),
        .serializer_power_down_q(ser_pd), .link_clock_enable_q(lclk_en),
        .fifo_reinit_q(reinit), .link_sync_request_q(sreq),
        .lmfc_edge_q(edge_q), .nco_sync_pulse_q(nsync),
        .nco_select_a_q(nsel_a_q), .nco_select_b_q(nsel_b_q),
        .summary_alarm_q(sum_q), .calibration_status_pin_q(pin_q));
    alm_rx_model alm_rx_model_inst (.mclk(mclk), .resetn(resetn),
        .link_reset_n_q(lrst_n), .sync_n(sync_n), .ilas_start(ilas_start),
        .link_in_data_state(in_data));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Matching channels; a bump forces a difference while it is held
    always @(posedge mclk) begin
        nco_acc_a <= nco_acc_a + 32'h3;
        nco_acc_b <= (nco_acc_a + 32'h3) ^ {31'h0, nco_bump};
        clk_a <= clk_a + 4'h1;
        clk_b <= (clk_a + 4'h1) ^ {3'h0, clk_bump};
    end
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata_q;
    endtask
    task automatic chk_bit(input int b, input logic e);
        rd_reg(OFS_ALARM_STATUS_BITS, d);
        chk({31'h0, d[b]}, {31'h0, e});
    endtask
    initial begin
        #800000 n_errors++;
        report_and_stop();
    end
    initial begin
        {wr, rd, sysref, nco_bump, clk_bump} = '0;
        {addr, wdata, lane_err, nco_acc_a, nco_acc_b, clk_a, clk_b} = '0;
        pd_pin = 1'b1;
        pll_locked = 1'b1;
        sel_a = 2'h1;
        sel_b = 2'h2;
        resetn = 1'b0;
        tick(2);
        resetn <= 1'b1;
        for (k = 0; k < 6; k++) begin
            rd_reg(ofs[k], d);
            chk(d, rstv[k]);
        end
        chk({28'h0, nsel_b_q, nsel_a_q}, 32'h9);
        $display("Test reset values done");
        pd_pin <= 1'b0;
        tick(8);
        chk_bit(ALM_CLK, 1'b1);
        wr_reg(OFS_ALARM_STATUS_BITS, 32'h3F);
        rd_reg(OFS_ALARM_STATUS_BITS, d);
        chk(d, 32'h0);
        wr_reg(OFS_LINK_CTRL, 32'h23);
        tick(3);
        chk({28'h0, sreq, lrst_n, ser_pd, lclk_en}, 32'hD);
        tick(20);
        chk({31'h0, sreq}, 32'h0);
        wr_reg(OFS_ALARM_STATUS_BITS, 32'h3F);
        $display("Test link enable done");
        @(posedge mclk) pll_locked <= 1'b0;
        @(posedge mclk) pll_locked <= 1'b1;
        tick(6);
        chk_bit(ALM_PLL, 1'b1);
        wr_reg(OFS_ALARM_STATUS_BITS, 32'h0);
        chk_bit(ALM_PLL, 1'b1);
        chk({30'h0, sum_q, pin_q}, 32'h3);
        wr_reg(OFS_ALARM_STATUS_BITS, 32'h1 << ALM_PLL);
        tick(3);
        chk({31'h0, sum_q}, 32'h0);
        wr_reg(OFS_ALM_MASK, 32'h1 << ALM_PLL);
        @(posedge mclk) pll_locked <= 1'b0;
        @(posedge mclk) pll_locked <= 1'b1;
        tick(6);
        chk_bit(ALM_PLL, 1'b1);
        chk({31'h0, sum_q}, 32'h0);
        wr_reg(OFS_ALM_MASK, 32'h0);
        tick(3);
        chk({31'h0, sum_q}, 32'h1);
        wr_reg(OFS_ALARM_STATUS_BITS, 32'h3F);
        $display("Test alarm and mask done");
        @(posedge mclk) sysref <= 1'b1;
        @(posedge mclk) sysref <= 1'b0;
        tick(2);
        chk({31'h0, edge_q}, 32'h1);
        tick(4);
        rd_reg(OFS_SUMMARY, d);
        chk({31'h0, d[SUM_NCO_SYNCED]}, 32'h1);
        wr_reg(OFS_ALARM_STATUS_BITS, 32'h3F);
        chk_bit(ALM_NCO, 1'b0);
        @(posedge mclk) nco_bump <= 1'b1;
        @(posedge mclk) nco_bump <= 1'b0;
        tick(4);
        chk_bit(ALM_NCO, 1'b1);
        @(posedge mclk) clk_bump <= 1'b1;
        repeat (2) @(posedge mclk);
        clk_bump <= 1'b0;
        tick(4);
        chk_bit(ALM_CLK, 1'b1);
        $display("Test upset detection done");
        wr_reg(OFS_ALARM_STATUS_BITS, 32'h3F);
        @(posedge mclk) lane_err <= 16'h0008;
        @(posedge mclk) lane_err <= 16'h0000;
        // The reinit pulse is launched by this edge; look after it settles
        #1;
        for (k = 0; k < 4 && reinit !== 1'b1; k++) tick(1);
        chk({31'h0, reinit}, 32'h1);
        tick(30);
        chk_bit(ALM_FIFO, 1'b1);
        rd_reg(OFS_LANE_ALM, d);
        chk(d, 32'h8);
        $display("Test lane fifo done");
        // Subclass 0, 64B/66B, NCO sync by lane alignment start
        wr_reg(OFS_LINK_CTRL, 32'h20);
        wr_reg(OFS_LINK_CTRL, 32'h38);
        rd_reg(OFS_SUMMARY, d);
        chk({31'h0, d[SUM_NCO_SYNCED]}, 32'h0);
        wr_reg(OFS_LINK_CTRL, 32'h3D);
        tick(3);
        chk({31'h0, sreq}, 32'h0);
        for (k = 0; k < 20 && nsync !== 1'b1; k++) tick(1);
        chk({31'h0, nsync}, 32'h1);
        rd_reg(OFS_SUMMARY, d);
        chk({31'h0, d[SUM_NCO_SYNCED]}, 32'h1);
        wr_reg(OFS_ALARM_STATUS_BITS, 32'h3F);
        @(posedge mclk) sysref <= 1'b1;
        @(posedge mclk) sysref <= 1'b0;
        tick(6);
        chk_bit(ALM_SYSREF, 1'b0);
        for (k = 0; k < 40 && edge_q !== 1'b1; k++) tick(1);
        chk({31'h0, edge_q}, 32'h1);
        tick(int'(RST_MF_PERIOD) - 1);
        chk({31'h0, edge_q}, 32'h0);
        tick(1);
        chk({31'h0, edge_q}, 32'h1);
        wr_reg(OFS_NCO_SEL, 32'h19);
        tick(2);
        chk({28'h0, nsel_b_q, nsel_a_q}, 32'hC);
        $display("Test link modes done");
        report_and_stop();
    end
endmodule
`default_nettype wire
